// ==== design/gcc_pkg.sv ====
// shared constants, types and reset values for the generic clock controller
package gcc_pkg;
	localparam int GCC_NGEN    = 8;
	localparam int GCC_NCLK    = 4;
	localparam int GCC_NSYN    = 14;
	localparam int GCC_SYN_PIN = 6;
	// register offsets
	localparam logic [7:0] GCC_OFF_CTRL   = 8'h00;
	localparam logic [7:0] GCC_OFF_STATUS = 8'h04;
	localparam logic [7:0] GCC_OFF_CLKSEL = 8'h08;
	localparam logic [7:0] GCC_OFF_GENCTL = 8'h0c;
	localparam logic [7:0] GCC_OFF_GENERATOR_DIVISION = 8'h10;
	// field positions
	localparam int GCC_CTRL_SRST  = 0;
	localparam int GCC_FLD_LSB    = 8;
	localparam int GCC_CLK_EN     = 14;
	localparam int GCC_CLK_LOCK   = 15;
	localparam int GCC_GEN_ON     = 16;
	localparam int GCC_GEN_OE     = 19;
	localparam int GCC_GEN_DSTYLE = 20;
	localparam int GCC_ST_CLK_LSB = 8;
	localparam logic [3:0] GCC_STRB_ID   = 4'h1;
	localparam logic [3:0] GCC_STRB_HALF = 4'h3;
	localparam logic [3:0] GCC_STRB_WORD = 4'hf;
	// fixed indexes
	localparam logic [2:0] GCC_GEN_MAIN = 3'h0;
	localparam logic [2:0] GCC_GEN_SLOW = 3'h2;
	localparam int GCC_CLK_WDT = 0;
	localparam int GCC_CLK_RTC = 1;
	// reset values of the synchronous clocks
	localparam logic [1:0] GCC_RC_DIV_RESET  = 2'h3;
	localparam logic [2:0] GCC_SYS_DIV_RESET = 3'h0;

	typedef enum logic [2:0] {
		GCC_SRC_RC   = 3'h0,
		GCC_SRC_ULP  = 3'h1,
		GCC_SRC_AUX0 = 3'h2,
		GCC_SRC_AUX1 = 3'h3,
		GCC_SRC_AUX2 = 3'h4,
		GCC_SRC_AUX3 = 3'h5,
		GCC_SRC_PIN  = 3'h6,
		GCC_SRC_GEN1 = 3'h7
	} gcc_src_t;

	typedef struct packed {
		logic        on;
		logic        oe;
		logic        dstyle;
		gcc_src_t    src;
		logic [15:0] div;
	} gcc_gen_t;

	typedef struct packed {
		logic       en;
		logic       lock;
		logic [2:0] gen;
	} gcc_clk_t;

	typedef enum logic [2:0] {
		GCC_H_IDLE = 3'h0,
		GCC_H_DIV  = 3'h1,
		GCC_H_GEN  = 3'h2,
		GCC_H_CLK  = 3'h3,
		GCC_H_RST  = 3'h4
	} gcc_hst_t;

	// initial generator setting
	function automatic gcc_gen_t gcc_gen_init(input int g);
		gcc_gen_t v;
		v = '0;
		v.on  = (g == int'(GCC_GEN_MAIN)) || (g == int'(GCC_GEN_SLOW));
		v.src = (g == int'(GCC_GEN_SLOW)) ? GCC_SRC_ULP : GCC_SRC_RC;
		return v;
	endfunction

	// initial generic clock setting
	function automatic gcc_clk_t gcc_clk_init(input int c);
		gcc_clk_t v;
		v = '0;
		v.en  = (c == GCC_CLK_WDT);
		v.gen = (c == GCC_CLK_WDT) ? GCC_GEN_SLOW : 3'h0;
		return v;
	endfunction
endpackage

// ==== design/gcc_link_if.sv ====
// apb link between the configuring party and the clock controller
`timescale 1ns/100ps
`default_nettype none
interface gcc_link_if (
	input wire logic pclk,
	input wire logic presetn
);
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [3:0]  pstrb;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;

	modport dev (
		input  pclk, presetn, psel, penable, pwrite, paddr, pwdata, pstrb,
		output prdata, pready, pslverr
	);
	modport host (
		input  pclk, presetn, prdata, pready, pslverr,
		output psel, penable, pwrite, paddr, pwdata, pstrb
	);
endinterface
`default_nettype wire

// ==== design/gcc_ctrl.sv ====
// generic clock controller: eight generators, four generic clocks, apb registers
// Functional notes
// - any reset: rc oscillator on, divided by eight
// - any reset: cpu and bus undivided
// - power reset: only generators zero, two run
// - power reset: only watchdog clock, from generator two
// - user reset keeps locked, watchdog, rtc clocks
// - 32k source reset only by power reset
// - eight generators feed generic clock multiplexers
// - eight sources; generator one cannot self-source
// - generator pin is input or clock output
// - per-generator divide and independent enable
// - generator zero drives the main clock
// - any generator selectable by many clocks
// - software enables sources before dependent clocks
// - software sets division with one word write
// - word write with enable starts a generator
// - software configures clock with halfword write
// - no global enable for the controller
// - soft reset restores all but locked ones
// - writes protectable except halted or debugger
// - bus access gated by power manager mask
// - lock ignores clock and generator writes, generator zero excepted
`timescale 1ns/100ps
`default_nettype none
module gcc_ctrl
	import gcc_pkg::*;
(
	gcc_link_if.dev          lk,
	input  wire logic        user_reset,
	input  wire logic        bridge_a_clock_mask,
	input  wire logic        guard_protect,
	input  wire logic        cpu_halted,
	input  wire logic        ext_debug,
	input  wire logic        wdt_always_on,
	input  wire logic        rc_8mhz_osc,
	input  wire logic        ulp_32k_osc,
	input  wire logic [3:0]  aux_src,
	input  wire logic [7:0]  gen_clock_pin_in,
	output logic      [7:0]  gen_clock_pin_out,
	output logic      [7:0]  gen_clock_pin_oe,
	output logic             main_clock,
	output logic      [3:0]  peripheral_clock,
	output logic             rc_osc_on,
	output logic      [1:0]  rc_osc_div,
	output logic             ulp_osc_on,
	output logic      [2:0]  cpu_div,
	output logic      [2:0]  bus_div
);
	typedef struct packed {
		gcc_gen_t [GCC_NGEN-1:0]       gen;
		gcc_clk_t [GCC_NCLK-1:0]       clk;
		logic [GCC_NGEN-1:0][16:0]     cnt;
		logic [GCC_NGEN-1:0]           grun;
		logic [GCC_NGEN-1:0]           gout;
		logic                          g1p;
		logic [GCC_NCLK-1:0]           crun;
		logic [GCC_NCLK-1:0][2:0]      csel;
		logic [GCC_NSYN-1:0][2:0]      sy;
		logic [GCC_NSYN-1:0]           lvl;
		logic [GCC_NSYN-1:0]           lvlp;
		logic [1:0]                    rclk;
		logic [2:0]                    rgctl;
		logic [2:0]                    rgdiv;
		logic                          pready;
		logic                          pslverr;
		logic [31:0]                   prdata;
		logic [7:0]                    pin_out;
		logic [7:0]                    pin_oe;
		logic                          main_clk;
		logic [GCC_NCLK-1:0]           pclk_out;
		logic                          rc_on;
		logic [1:0]                    rc_div;
		logic                          ulp_on;
		logic [2:0]                    cpu_d;
		logic [2:0]                    bus_d;
	} gcc_dev_t;

	gcc_dev_t r_r;
	gcc_dev_t r_nxt;

	// power-reset contents of the whole state
	function automatic gcc_dev_t dev_init();
		gcc_dev_t v;
		v = '0;
		for (int g = 0; g < GCC_NGEN; g++)
		begin
			v.gen[g] = gcc_gen_init(g);
		end
		for (int c = 0; c < GCC_NCLK; c++)
		begin
			v.clk[c] = gcc_clk_init(c);
		end
		v.rc_on  = 1'b1;
		v.rc_div = GCC_RC_DIV_RESET;
		v.ulp_on = 1'b1;
		v.cpu_d  = GCC_SYS_DIV_RESET;
		v.bus_d  = GCC_SYS_DIV_RESET;
		return v;
	endfunction

	logic [GCC_NSYN-1:0] raw;
	logic [GCC_NGEN-1:0] glock;
	logic [GCC_NGEN-1:0] gkeep;
	logic [GCC_NCLK-1:0] ckeep;
	logic                prot;
	logic                wr;
	logic                now;
	logic                prev;
	logic [16:0]         nn;
	logic [16:0]         cn;
	logic [5:0]          cid;
	logic [3:0]          gid;
	logic [2:0]          gs;

	always_comb
	begin
		r_nxt = r_r;
		raw   = {gen_clock_pin_in, aux_src, ulp_32k_osc, rc_8mhz_osc};
		glock = '0;
		gkeep = '0;
		ckeep = '0;
		now   = 1'b0;
		prev  = 1'b0;
		nn    = '0;
		cn    = '0;
		cid   = lk.pwdata[5:0];
		gid   = lk.pwdata[3:0];
		gs    = '0;
		// three-stage input synchronisers, change accepted when stages two and three agree
		for (int i = 0; i < GCC_NSYN; i++)
		begin
			r_nxt.sy[i] = {r_r.sy[i][1:0], raw[i]};
			if (r_r.sy[i][1] == r_r.sy[i][2])
				r_nxt.lvl[i] = r_r.sy[i][2];
		end
		r_nxt.lvlp = r_r.lvl;
		r_nxt.g1p  = r_r.gout[1];
		// a locked clock locks its generator, generator zero excepted
		for (int c = 0; c < GCC_NCLK; c++)
		begin
			if (r_r.clk[c].lock && (r_r.clk[c].gen != GCC_GEN_MAIN))
				glock[r_r.clk[c].gen] = 1'b1;
		end
		// apb setup phase: answer in the following cycle
		prot            = guard_protect && !cpu_halted && !ext_debug;
		r_nxt.pready    = 1'b0;
		r_nxt.pslverr   = 1'b0;
		r_nxt.prdata    = '0;
		if (lk.psel && !lk.penable)
		begin
			r_nxt.pready = 1'b1;
			case (lk.paddr)
				GCC_OFF_CTRL:   r_nxt.prdata = '0;
				GCC_OFF_STATUS: r_nxt.prdata = {20'h0, r_r.crun, r_r.grun};
				GCC_OFF_CLKSEL: r_nxt.prdata = {16'h0, r_r.clk[r_r.rclk].lock, r_r.clk[r_r.rclk].en,
					3'h0, r_r.clk[r_r.rclk].gen, 6'h0, r_r.rclk};
				GCC_OFF_GENCTL: r_nxt.prdata = {11'h0, r_r.gen[r_r.rgctl].dstyle, r_r.gen[r_r.rgctl].oe,
					2'h0, r_r.gen[r_r.rgctl].on, 5'h0, r_r.gen[r_r.rgctl].src, 5'h0, r_r.rgctl};
				GCC_OFF_GENERATOR_DIVISION: r_nxt.prdata = {8'h0, r_r.gen[r_r.rgdiv].div, 5'h0, r_r.rgdiv};
				default:        r_nxt.pslverr = 1'b1;
			endcase
			if (lk.pwrite && prot && bridge_a_clock_mask)
				r_nxt.pslverr = 1'b1;
			if (!bridge_a_clock_mask)
				r_nxt.prdata = '0;
		end
		// writes take effect at the completing edge only
		wr = lk.psel && lk.penable && r_r.pready && lk.pwrite && !r_r.pslverr && bridge_a_clock_mask;
		if (wr)
		begin
			case (lk.paddr)
				GCC_OFF_CLKSEL:
				begin
					if (cid < 6'(GCC_NCLK))
					begin
						r_nxt.rclk = cid[1:0];
						if (lk.pstrb != GCC_STRB_ID && !r_r.clk[cid[1:0]].lock)
						begin
							r_nxt.clk[cid[1:0]].gen  = lk.pwdata[GCC_FLD_LSB +: 3];
							r_nxt.clk[cid[1:0]].en   = lk.pwdata[GCC_CLK_EN];
							r_nxt.clk[cid[1:0]].lock = lk.pwdata[GCC_CLK_LOCK];
						end
					end
				end
				GCC_OFF_GENCTL:
				begin
					if (gid < 4'(GCC_NGEN))
					begin
						r_nxt.rgctl = gid[2:0];
						if (lk.pstrb != GCC_STRB_ID && !glock[gid[2:0]])
						begin
							r_nxt.gen[gid[2:0]].on     = lk.pwdata[GCC_GEN_ON];
							r_nxt.gen[gid[2:0]].oe     = lk.pwdata[GCC_GEN_OE];
							r_nxt.gen[gid[2:0]].dstyle = lk.pwdata[GCC_GEN_DSTYLE];
							if (!(gid == 4'h1 && gcc_src_t'(lk.pwdata[GCC_FLD_LSB +: 3]) == GCC_SRC_GEN1))
								r_nxt.gen[gid[2:0]].src = gcc_src_t'(lk.pwdata[GCC_FLD_LSB +: 3]);
						end
					end
				end
				GCC_OFF_GENERATOR_DIVISION:
				begin
					if (gid < 4'(GCC_NGEN))
					begin
						r_nxt.rgdiv = gid[2:0];
						if (lk.pstrb != GCC_STRB_ID && !glock[gid[2:0]])
							r_nxt.gen[gid[2:0]].div = lk.pwdata[GCC_FLD_LSB +: 16];
					end
				end
				default: ;
			endcase
		end
		// user or soft reset: restore all except the spared clocks and generators
		if (user_reset || (wr && lk.paddr == GCC_OFF_CTRL && lk.pwdata[GCC_CTRL_SRST]))
		begin
			for (int c = 0; c < GCC_NCLK; c++)
				ckeep[c] = r_r.clk[c].lock;
			if (user_reset)
			begin
				ckeep[GCC_CLK_WDT] = ckeep[GCC_CLK_WDT] | wdt_always_on;
				ckeep[GCC_CLK_RTC] = ckeep[GCC_CLK_RTC] | r_r.clk[GCC_CLK_RTC].en;
				r_nxt.rc_on  = 1'b1;
				r_nxt.rc_div = GCC_RC_DIV_RESET;
				r_nxt.cpu_d  = GCC_SYS_DIV_RESET;
				r_nxt.bus_d  = GCC_SYS_DIV_RESET;
			end
			for (int c = 0; c < GCC_NCLK; c++)
			begin
				if (ckeep[c])
					gkeep[r_r.clk[c].gen] = 1'b1;
				else
					r_nxt.clk[c] = gcc_clk_init(c);
			end
			gkeep[GCC_GEN_MAIN] = 1'b0;
			for (int g = 0; g < GCC_NGEN; g++)
			begin
				if (!gkeep[g])
					r_nxt.gen[g] = gcc_gen_init(g);
			end
			r_nxt.rclk  = '0;
			r_nxt.rgctl = '0;
			r_nxt.rgdiv = '0;
		end
		// generators: pick source, divide, start and stop only while low
		for (int g = 0; g < GCC_NGEN; g++)
		begin
			case (r_r.gen[g].src)
				GCC_SRC_RC:   begin now = r_r.lvl[0]; prev = r_r.lvlp[0]; end
				GCC_SRC_ULP:  begin now = r_r.lvl[1]; prev = r_r.lvlp[1]; end
				GCC_SRC_PIN:  begin now = r_r.lvl[GCC_SYN_PIN + g]; prev = r_r.lvlp[GCC_SYN_PIN + g]; end
				GCC_SRC_GEN1: begin now = r_r.gout[1]; prev = r_r.g1p; end
				default:      begin now = r_r.lvl[r_r.gen[g].src]; prev = r_r.lvlp[r_r.gen[g].src]; end
			endcase
			if (r_r.gen[g].dstyle)
				nn = 17'h1 << (5'(r_r.gen[g].div[3:0]) + 5'h1);
			else
				nn = {1'b0, r_r.gen[g].div};
			if (r_r.grun[g])
			begin
				if (nn <= 17'h1)
					r_nxt.gout[g] = now;
				else if (now && !prev)
				begin
					cn = (r_r.cnt[g] >= nn - 17'h1) ? 17'h0 : r_r.cnt[g] + 17'h1;
					r_nxt.cnt[g]  = cn;
					r_nxt.gout[g] = cn < (nn >> 1);
				end
				if (!r_r.gen[g].on && !r_r.gout[g])
				begin
					r_nxt.grun[g] = 1'b0;
					r_nxt.gout[g] = 1'b0;
					r_nxt.cnt[g]  = '0;
				end
			end
			else if (r_r.gen[g].on && !now)
				r_nxt.grun[g] = 1'b1;
			r_nxt.pin_oe[g]  = r_r.gen[g].on && r_r.gen[g].oe && (r_r.gen[g].src != GCC_SRC_PIN);
			r_nxt.pin_out[g] = r_r.gen[g].oe && r_nxt.gout[g];
		end
		// generic clock multiplexers, selection and enable change only while the selected generator is low
		for (int c = 0; c < GCC_NCLK; c++)
		begin
			gs = r_r.crun[c] ? r_r.csel[c] : r_r.clk[c].gen;
			if (!r_r.gout[gs])
			begin
				r_nxt.crun[c] = r_r.clk[c].en;
				r_nxt.csel[c] = r_r.clk[c].gen;
			end
			r_nxt.pclk_out[c] = r_nxt.crun[c] && r_nxt.gout[r_nxt.csel[c]];
		end
		r_nxt.main_clk = r_nxt.gout[GCC_GEN_MAIN];
	end

	// single state register, no global enable anywhere
	always_ff @(posedge lk.pclk or negedge lk.presetn)
	begin
		if (!lk.presetn)
			r_r <= dev_init();
		else
			r_r <= r_nxt;
	end

	assign lk.prdata         = r_r.prdata;
	assign lk.pready         = r_r.pready;
	assign lk.pslverr        = r_r.pslverr;
	assign gen_clock_pin_out = r_r.pin_out;
	assign gen_clock_pin_oe  = r_r.pin_oe;
	assign main_clock        = r_r.main_clk;
	assign peripheral_clock  = r_r.pclk_out;
	assign rc_osc_on         = r_r.rc_on;
	assign rc_osc_div        = r_r.rc_div;
	assign ulp_osc_on        = r_r.ulp_on;
	assign cpu_div           = r_r.cpu_d;
	assign bus_div           = r_r.bus_d;
endmodule
`default_nettype wire

// ==== design/gcc_host.sv ====
// configuring party: runs the three-step clock set-up or a soft reset over apb
`timescale 1ns/100ps
`default_nettype none
module gcc_host
	import gcc_pkg::*;
(
	gcc_link_if.host         lk,
	input  wire logic        cmd_valid,
	input  wire logic        cmd_srst,
	input  wire logic [2:0]  cmd_gen,
	input  wire logic [2:0]  cmd_src,
	input  wire logic [15:0] cmd_div,
	input  wire logic        cmd_dstyle,
	input  wire logic        cmd_oe,
	input  wire logic [5:0]  cmd_clk,
	input  wire logic        cmd_lock,
	output logic             cmd_ready,
	output logic             cmd_done,
	output logic             cmd_err
);
	typedef struct packed {
		gcc_hst_t    st;
		logic [2:0]  gen;
		logic [2:0]  src;
		logic [15:0] div;
		logic        dstyle;
		logic        oe;
		logic [5:0]  clk;
		logic        lock;
		logic        psel;
		logic        penable;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
		logic [3:0]  pstrb;
		logic        ready;
		logic        done;
		logic        err;
	} gcc_hstate_t;

	gcc_hstate_t r_r;
	gcc_hstate_t r_nxt;

	always_comb
	begin
		r_nxt      = r_r;
		r_nxt.done = 1'b0;
		// sequencing: division, then generator enable, then generic clock
		if (r_r.st == GCC_H_IDLE)
		begin
			if (cmd_valid)
			begin
				r_nxt.st     = cmd_srst ? GCC_H_RST : GCC_H_DIV;
				r_nxt.gen    = cmd_gen;
				r_nxt.src    = cmd_src;
				r_nxt.div    = cmd_div;
				r_nxt.dstyle = cmd_dstyle;
				r_nxt.oe     = cmd_oe;
				r_nxt.clk    = cmd_clk;
				r_nxt.lock   = cmd_lock;
				r_nxt.ready  = 1'b0;
				r_nxt.err    = 1'b0;
				r_nxt.psel   = 1'b1;
			end
		end
		else if (!r_r.penable)
			r_nxt.penable = 1'b1;
		else if (lk.pready)
		begin
			r_nxt.err     = r_r.err | lk.pslverr;
			r_nxt.penable = 1'b0;
			case (r_r.st)
				GCC_H_DIV: r_nxt.st = GCC_H_GEN;
				GCC_H_GEN: r_nxt.st = GCC_H_CLK;
				default:
				begin
					r_nxt.st    = GCC_H_IDLE;
					r_nxt.psel  = 1'b0;
					r_nxt.ready = 1'b1;
					r_nxt.done  = 1'b1;
				end
			endcase
		end
		// request words, loaded at each setup cycle and then held
		if (r_nxt.psel && !r_nxt.penable)
		begin
			case (r_nxt.st)
				GCC_H_DIV:
				begin
					r_nxt.paddr  = GCC_OFF_GENERATOR_DIVISION;
					r_nxt.pwdata = {8'h0, r_nxt.div, 5'h0, r_nxt.gen};
					r_nxt.pstrb  = GCC_STRB_WORD;
				end
				GCC_H_GEN:
				begin
					r_nxt.paddr  = GCC_OFF_GENCTL;
					r_nxt.pwdata = {11'h0, r_nxt.dstyle, r_nxt.oe, 2'h0, 1'b1, 5'h0, r_nxt.src, 5'h0, r_nxt.gen};
					r_nxt.pstrb  = GCC_STRB_WORD;
				end
				GCC_H_CLK:
				begin
					r_nxt.paddr  = GCC_OFF_CLKSEL;
					r_nxt.pwdata = {16'h0, r_nxt.lock, 1'b1, 3'h0, r_nxt.gen, 2'h0, r_nxt.clk};
					r_nxt.pstrb  = GCC_STRB_HALF;
				end
				default:
				begin
					r_nxt.paddr  = GCC_OFF_CTRL;
					r_nxt.pwdata = 32'h0000_0001;
					r_nxt.pstrb  = GCC_STRB_WORD;
				end
			endcase
		end
	end

	always_ff @(posedge lk.pclk or negedge lk.presetn)
	begin
		if (!lk.presetn)
		begin
			r_r       <= '0;
			r_r.ready <= 1'b1;
		end
		else
			r_r <= r_nxt;
	end

	assign lk.psel    = r_r.psel;
	assign lk.penable = r_r.penable;
	assign lk.pwrite  = 1'b1;
	assign lk.paddr   = r_r.paddr;
	assign lk.pwdata  = r_r.pwdata;
	assign lk.pstrb   = r_r.pstrb;
	assign cmd_ready  = r_r.ready;
	assign cmd_done   = r_r.done;
	assign cmd_err    = r_r.err;
endmodule
`default_nettype wire

// ==== verif/gcc_link_monitor.sv ====
// protocol and configuration-order checks on the apb link between host and controller
`timescale 1ns/100ps
`default_nettype none
module gcc_link_monitor
	import gcc_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic        setup;
	logic [7:0]  prev_addr_r;
	logic [31:0] prev_data_r;
	// setup phase of a transfer
	assign setup = psel && !penable;
	// remembers the previous transfer so the set-up order can be judged
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prev_addr_r <= 8'hff;
			prev_data_r <= 32'h0;
		end
		else if (setup)
		begin
			prev_addr_r <= paddr;
			prev_data_r <= pwdata;
		end
	end
	div_word_a: assert property (setup && paddr == GCC_OFF_GENERATOR_DIVISION |-> pstrb == GCC_STRB_WORD)
		else $error("division write is not a full word");
	gen_word_on_a: assert property (setup && paddr == GCC_OFF_GENCTL |-> pstrb == GCC_STRB_WORD && pwdata[GCC_GEN_ON])
		else $error("generator write is not a word with the enable set");
	gen_same_id_a: assert property (setup && paddr == GCC_OFF_GENCTL |-> prev_addr_r == GCC_OFF_GENERATOR_DIVISION && prev_data_r[3:0] == pwdata[3:0])
		else $error("generator write not preceded by its division write");
	clk_half_a: assert property (setup && paddr == GCC_OFF_CLKSEL |-> pstrb == GCC_STRB_HALF && pwdata[GCC_CLK_EN])
		else $error("clock select write is not an enabling halfword");
	clk_after_gen_a: assert property (setup && paddr == GCC_OFF_CLKSEL |-> prev_addr_r == GCC_OFF_GENCTL && pwdata[10:8] == prev_data_r[2:0])
		else $error("clock enabled before its generator");
	ready_next_a: assert property (setup |=> penable && pready && $stable(paddr) && $stable(pwdata))
		else $error("no answer in the access cycle");
	ready_in_access_a: assert property (pready |-> psel && penable && $past(setup))
		else $error("ready outside the first access cycle");
	release_after_a: assert property (psel && penable && pready |=> !penable)
		else $error("access phase not released after ready");
	srst_bit_a: assert property (setup && paddr == GCC_OFF_CTRL |-> pwdata[GCC_CTRL_SRST])
		else $error("control write without the soft reset bit");
	write_only_a: assert property (psel |-> pwrite)
		else $error("host issued a read");
	ctrl_reads_zero_a: assert property (pready && paddr == GCC_OFF_CTRL |-> prdata == 32'h0)
		else $error("control register does not read as zero");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("error flag without ready");
endmodule
`default_nettype wire

// ==== verif/generic_clock_controller_tb.sv ====
// self-checking bench: host and controller joined by the apb link
`timescale 1ns/100ps
`default_nettype none
module generic_clock_controller_tb
	import gcc_pkg::*;
;
	typedef struct packed {
		logic [2:0]  gen;
		logic [2:0]  src;
		logic [15:0] div;
		logic        sty;
		logic [5:0]  clk;
		logic [3:0]  w;
		logic [7:0]  per;
		logic        oe;
	} gcc_row_t;
	logic        pclk, presetn, user_reset, mask, guard, halted, dbg, wdt_on, rc, ulp, pin6;
	logic [3:0]  aux;
	logic        c_valid, c_srst, c_sty, c_oe, c_lock, c_ready, c_done, c_err;
	logic [2:0]  c_gen, c_src, cpu_div, bus_div;
	logic [15:0] c_div;
	logic [5:0]  c_clk;
	logic [7:0]  pin_out, pin_oe;
	logic        main_clk, rc_on, ulp_on;
	logic [3:0]  per_clk;
	logic [1:0]  rc_div;
	logic [2:0]  acc;
	gcc_row_t    rows [6];
	gcc_row_t    r;
	int          checks, error_cnt;
	gcc_link_if i_gcc_link_if (.pclk(pclk), .presetn(presetn));
	gcc_ctrl i_gcc_ctrl (.lk(i_gcc_link_if), .user_reset(user_reset), .bridge_a_clock_mask(mask),
		.guard_protect(guard), .cpu_halted(halted), .ext_debug(dbg), .wdt_always_on(wdt_on),
		.rc_8mhz_osc(rc), .ulp_32k_osc(ulp), .aux_src(aux), .gen_clock_pin_in({1'b0, pin6, 6'h0}),
		.gen_clock_pin_out(pin_out), .gen_clock_pin_oe(pin_oe), .main_clock(main_clk), .peripheral_clock(per_clk),
		.rc_osc_on(rc_on), .rc_osc_div(rc_div), .ulp_osc_on(ulp_on), .cpu_div(cpu_div), .bus_div(bus_div));
	gcc_host i_gcc_host (.lk(i_gcc_link_if), .cmd_valid(c_valid), .cmd_srst(c_srst), .cmd_gen(c_gen),
		.cmd_src(c_src), .cmd_div(c_div), .cmd_dstyle(c_sty), .cmd_oe(c_oe), .cmd_clk(c_clk), .cmd_lock(c_lock),
		.cmd_ready(c_ready), .cmd_done(c_done), .cmd_err(c_err));
	gcc_link_monitor i_gcc_link_monitor (.pclk(pclk), .presetn(presetn), .psel(i_gcc_link_if.psel),
		.penable(i_gcc_link_if.penable), .pwrite(i_gcc_link_if.pwrite), .paddr(i_gcc_link_if.paddr),
		.pwdata(i_gcc_link_if.pwdata), .pstrb(i_gcc_link_if.pstrb), .prdata(i_gcc_link_if.prdata),
		.pready(i_gcc_link_if.pready), .pslverr(i_gcc_link_if.pslverr));
	// bus clock, 4 ns period
	initial
	begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	// free-running sources; edges land on falling clock edges only
	always #32 rc = ~rc;
	always #96 ulp = ~ulp;
	always #40 aux[0] = ~aux[0];
	always #48 aux[1] = ~aux[1];
	always #56 aux[2] = ~aux[2];
	always #64 aux[3] = ~aux[3];
	always #80 pin6 = ~pin6;
	// compare and count
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task results;
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// one host command, waits for its completion pulse
	task cmd(input logic srst, input gcc_row_t x, input logic lock);
		int n;
		@(posedge pclk);
		c_valid <= 1'b1;
		{c_srst, c_gen, c_src, c_div, c_sty, c_oe, c_clk, c_lock} <= {srst, x.gen, x.src, x.div, x.sty, x.oe, x.clk, lock};
		@(posedge pclk);
		c_valid <= 1'b0;
		n = 0;
		while (c_done !== 1'b1 && n < 40)
		begin
			@(posedge pclk);
			n++;
		end
		// let state written at the last access edge reach the registered outputs
		@(posedge pclk);
		chk({n < 40, c_ready}, 2'h3);
	endtask
	// picks an observed clock: pins 0-7, generic clocks 8-11, main clock 12
	function automatic logic obs(input int w);
		return w < 8 ? pin_out[w] : (w < 12 ? per_clk[w-8] : main_clk);
	endfunction
	// period between the second and third rising edge, in bus cycles
	task meas(input int w, input logic [31:0] exp);
		int n, k, t;
		logic p;
		p = obs(w);
		n = 0;
		k = 0;
		t = 0;
		while (k < 3 && n < 1500)
		begin
			@(posedge pclk);
			n++;
			if (obs(w) === 1'b1 && p === 1'b0)
			begin
				k++;
				if (k == 2)
					t = n;
			end
			p = obs(w);
		end
		chk(n - t, exp);
	endtask
	// oscillator and system divider state expected after any reset
	task osc_chk;
		chk({rc_on, rc_div, ulp_on, cpu_div, bus_div}, {1'b1, GCC_RC_DIV_RESET, 1'b1, GCC_SYS_DIV_RESET, GCC_SYS_DIV_RESET});
	endtask
	initial
	begin
		#200000;
		error_cnt++;
		results;
	end
	initial
	begin
		{presetn, user_reset, guard, halted, dbg, wdt_on, c_valid} = 7'h0;
		{rc, ulp, pin6, aux, mask} = 8'h1;
		{c_srst, c_gen, c_src, c_div, c_sty, c_oe, c_clk, c_lock} = '0;
		checks = 0;
		error_cnt = 0;
		rows[0] = '{3'h3, GCC_SRC_AUX0, 16'h2, 1'b0, 6'h3f, 4'h3, 8'd40, 1'b1};
		rows[1] = '{3'h4, GCC_SRC_RC, 16'h1, 1'b1, 6'h3f, 4'h4, 8'd64, 1'b1};
		rows[2] = '{3'h1, GCC_SRC_ULP, 16'h0, 1'b0, 6'h01, 4'h1, 8'd48, 1'b1};
		rows[3] = '{3'h5, GCC_SRC_GEN1, 16'h3, 1'b0, 6'h3f, 4'h5, 8'd144, 1'b1};
		rows[4] = '{3'h7, GCC_SRC_AUX3, 16'h1, 1'b0, 6'h3f, 4'h7, 8'd32, 1'b1};
		rows[5] = '{3'h6, GCC_SRC_PIN, 16'h1, 1'b0, 6'h02, 4'ha, 8'd40, 1'b0};
		repeat (8) @(posedge pclk);
		osc_chk();
		presetn <= 1'b1;
		@(posedge pclk);
		chk(pin_oe, 8'h0);
		meas(12, 16);
		meas(8, 48);
		acc = 3'h0;
		repeat (100)
		begin
			@(posedge pclk);
			acc = acc | per_clk[3:1];
		end
		chk(acc, 3'h0);
		$display("test power-on state done");
		// ordinary set-ups, one row each
		foreach (rows[i])
		begin
			cmd(1'b0, rows[i], 1'b0);
			chk(c_err, 1'b0);
			chk(pin_oe[rows[i].gen], rows[i].oe);
			meas(rows[i].w, rows[i].per);
			$display("test row %0d done", i);
		end
		// generator 1 may not take itself as source
		r = rows[2];
		r.src = GCC_SRC_GEN1;
		cmd(1'b0, r, 1'b0);
		meas(1, 48);
		$display("test self source done");
		// a locked clock and its generator ignore later writes
		r = '{3'h4, GCC_SRC_ULP, 16'h1, 1'b0, 6'h03, 4'hb, 8'd48, 1'b1};
		cmd(1'b0, r, 1'b1);
		r.src = GCC_SRC_RC;
		cmd(1'b0, r, 1'b0);
		meas(11, 48);
		meas(4, 48);
		$display("test lock done");
		cmd(1'b1, rows[0], 1'b0);
		chk(pin_oe, 8'h10);
		meas(11, 48);
		meas(12, 16);
		$display("test soft reset done");
		// write protection and its two exemptions, then the bus clock mask
		guard <= 1'b1;
		cmd(1'b0, rows[0], 1'b0);
		chk({c_err, pin_oe[3]}, 2'h2);
		halted <= 1'b1;
		cmd(1'b0, rows[0], 1'b0);
		chk({c_err, pin_oe[3]}, 2'h1);
		halted <= 1'b0;
		dbg <= 1'b1;
		cmd(1'b0, rows[4], 1'b0);
		chk({c_err, pin_oe[7]}, 2'h1);
		{guard, dbg, mask} <= 3'h0;
		cmd(1'b0, rows[2], 1'b0);
		chk({c_err, pin_oe}, 9'h098);
		mask <= 1'b1;
		$display("test protection done");
		// user reset keeps locked, rtc and their generators
		cmd(1'b0, rows[2], 1'b0);
		wdt_on <= 1'b1;
		@(posedge pclk);
		user_reset <= 1'b1;
		@(posedge pclk);
		user_reset <= 1'b0;
		repeat (2) @(posedge pclk);
		chk(pin_oe, 8'h12);
		osc_chk();
		meas(9, 48);
		meas(11, 48);
		meas(8, 48);
		$display("test user reset done");
		// a power reset in mid-run clears the lock
		presetn <= 1'b0;
		repeat (8) @(posedge pclk);
		osc_chk();
		presetn <= 1'b1;
		@(posedge pclk);
		chk(pin_oe, 8'h0);
		r.src = GCC_SRC_RC;
		cmd(1'b0, r, 1'b0);
		meas(11, 16);
		$display("test power reset done");
		results;
	end
endmodule
`default_nettype wire
